// File: design/dvs_ref_pkg.sv
package dvs_ref_pkg;

   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned RAILS         = 4;

   // serial port identity and command offsets
   localparam logic [6:0] DEV_ADDR          = 7'h34;
   localparam logic [7:0] FAULT_STATUS_OFS  = 8'h02;
   localparam logic [7:0] PG_STATUS_OFS     = 8'h13;
   localparam logic [7:0] VCC_CONTROL_OFS   = 8'h20;
   localparam logic [7:0] ALERT_CLEAR_OFS   = 8'h21;
   localparam logic [7:0] BUCK1_FIRST_OFS   = 8'h23;
   localparam logic [7:0] BUCK1_SECOND_OFS  = 8'h24;
   localparam logic [7:0] RAMP_RATE_OFS     = 8'h25;
   localparam logic [7:0] BUCK2_FIRST_OFS   = 8'h26;
   localparam logic [7:0] BUCK2_SECOND_OFS  = 8'h27;
   localparam logic [7:0] BUCK3_FIRST_OFS   = 8'h29;
   localparam logic [7:0] BUCK3_SECOND_OFS  = 8'h2a;
   localparam logic [7:0] LDO2_FIRST_OFS    = 8'h32;
   localparam logic [7:0] LDO2_SECOND_OFS   = 8'h33;

   // reset values
   localparam logic [7:0] TARGET_RST        = 8'h19;
   localparam logic [7:0] RAMP_RATE_RST     = 8'hff;
   localparam logic [3:0] VCC_CONTROL_RST   = 4'h0;

   // field positions
   localparam int unsigned CODE_MSB         = 4;
   localparam int unsigned PG_MASK_BIT      = 5;
   localparam int unsigned FREQ_BIT         = 5;
   localparam int unsigned EDGE_MSB         = 7;
   localparam int unsigned EDGE_LSB         = 6;
   localparam int unsigned FAULT_LSB        = 3;

   // writable bits per target register, unused bits read zero
   localparam logic [7:0] BUCK1_FIRST_WMASK = 8'hff;
   localparam logic [7:0] BUCKX_FIRST_WMASK = 8'h3f;
   localparam logic [7:0] LDO2_FIRST_WMASK  = 8'hbf;
   localparam logic [7:0] SECOND_WMASK      = 8'hff;

   // reference step is 12.5 mV; time per step at each ramp setting
   localparam int unsigned STEP_NS_RATE0    = 14205;
   localparam int unsigned STEP_NS_RATE1    = 7143;
   localparam int unsigned STEP_NS_RATE2    = 3572;
   localparam int unsigned STEP_NS_RATE3    = 1786;
   localparam int unsigned STEP_CYC_RATE0   = (STEP_NS_RATE0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STEP_CYC_RATE1   = (STEP_NS_RATE1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STEP_CYC_RATE2   = (STEP_NS_RATE2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STEP_CYC_RATE3   = (STEP_NS_RATE3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_ADDR_ACK, S_SUB, S_SUB_ACK, S_WDATA, S_WACK, S_RDATA, S_RACK
   } bus_state_t;

   typedef struct packed {
      logic [7:0] first;
      logic [7:0] second;
   } target_pair_t;

   typedef logic [RAILS-1:0][4:0] rail_codes_t;

endpackage

// File: design/dvs_reference_control.sv
`timescale 1ns/1ps
module dvs_reference_control (
   input  wire logic                      core_clk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      scl_i,
   input  wire logic                      sda_i,
   output logic                           sda_o,
   output logic                           sda_oe_n_o,
   input  wire logic                      standby_select_pin_i,
   input  wire logic                      fault_event_i,
   input  wire logic [4:0]                fault_status_i,
   input  wire logic [7:0]                rail_good_i,
   input  wire logic                      power_ok_i,
   output logic                           alert_n_o,
   output logic                           power_good_out_o,
   output dvs_ref_pkg::rail_codes_t       ref_code_o,
   output logic [3:0]                     slewing_o,
   output logic [1:0]                     edge_rate_o,
   output logic [2:0]                     freq_sel_o
);

   typedef struct packed {
      dvs_ref_pkg::bus_state_t              state;
      logic                                 scl_q;
      logic                                 sda_q;
      logic [7:0]                           shift;
      logic [3:0]                           bit_cnt;
      logic                                 rw;
      logic                                 nack;
      logic [7:0]                           ptr;
      logic                                 sda_oe_n;
      logic                                 alert_n;
      logic                                 pg;
      logic                                 stb_q;
      logic [3:0]                           sel;
      logic [3:0]                           go;
      logic [7:0]                           ramp;
      dvs_ref_pkg::target_pair_t [3:0]      tgt;
      dvs_ref_pkg::rail_codes_t             cur;
      logic [3:0][11:0]                     step_cnt;
   } state_t;

   state_t r_reg;
   state_t r_next;

   function automatic state_t init_state();
      state_t s;
      s          = '0;
      s.state    = dvs_ref_pkg::S_IDLE;
      s.scl_q    = 1'b1;
      s.sda_q    = 1'b1;
      s.sda_oe_n = 1'b1;
      s.alert_n  = 1'b1;
      s.sel      = dvs_ref_pkg::VCC_CONTROL_RST;
      s.go       = dvs_ref_pkg::VCC_CONTROL_RST;
      s.ramp     = dvs_ref_pkg::RAMP_RATE_RST;
      for (int i = 0; i < 4; i++) begin
         s.tgt[i].first  = dvs_ref_pkg::TARGET_RST;
         s.tgt[i].second = dvs_ref_pkg::TARGET_RST;
         s.cur[i]        = dvs_ref_pkg::TARGET_RST[4:0];
      end
      return s;
   endfunction

   localparam state_t RESET_STATE = init_state();

   // rail order: 0 buck1, 1 buck2, 2 buck3, 3 ldo2
   function automatic logic [4:0] target_code(dvs_ref_pkg::target_pair_t p, logic sel);
      return sel ? p.second[dvs_ref_pkg::CODE_MSB:0] : p.first[dvs_ref_pkg::CODE_MSB:0];
   endfunction

   function automatic logic [11:0] step_cycles(logic [1:0] rate);
      unique case (rate)
         2'h0: return 12'(dvs_ref_pkg::STEP_CYC_RATE0);
         2'h1: return 12'(dvs_ref_pkg::STEP_CYC_RATE1);
         2'h2: return 12'(dvs_ref_pkg::STEP_CYC_RATE2);
         2'h3: return 12'(dvs_ref_pkg::STEP_CYC_RATE3);
      endcase
   endfunction

   function automatic logic [7:0] read_reg(state_t s, logic [4:0] fault, logic [7:0] good);
      logic [7:0] v;
      v = 8'h00;
      unique case (s.ptr)
         dvs_ref_pkg::FAULT_STATUS_OFS: v = {fault, 3'h0};
         dvs_ref_pkg::PG_STATUS_OFS:    v = good;
         dvs_ref_pkg::VCC_CONTROL_OFS:
            v = {s.sel[3], s.go[3], s.sel[2], s.go[2], s.sel[1], s.go[1], s.sel[0], s.go[0]};
         dvs_ref_pkg::RAMP_RATE_OFS:    v = s.ramp;
         dvs_ref_pkg::BUCK1_FIRST_OFS:  v = s.tgt[0].first;
         dvs_ref_pkg::BUCK1_SECOND_OFS: v = s.tgt[0].second;
         dvs_ref_pkg::BUCK2_FIRST_OFS:  v = s.tgt[1].first;
         dvs_ref_pkg::BUCK2_SECOND_OFS: v = s.tgt[1].second;
         dvs_ref_pkg::BUCK3_FIRST_OFS:  v = s.tgt[2].first;
         dvs_ref_pkg::BUCK3_SECOND_OFS: v = s.tgt[2].second;
         dvs_ref_pkg::LDO2_FIRST_OFS:   v = s.tgt[3].first;
         dvs_ref_pkg::LDO2_SECOND_OFS:  v = s.tgt[3].second;
         default:                       v = 8'h00;
      endcase
      return v;
   endfunction

   logic       scl_rise;
   logic       scl_fall;
   logic       bus_start;
   logic       bus_stop;
   logic [3:0] pg_force;

   assign scl_rise  = scl_i & ~r_reg.scl_q;
   assign scl_fall  = ~scl_i & r_reg.scl_q;
   assign bus_start = scl_i & r_reg.scl_q & r_reg.sda_q & ~sda_i;
   assign bus_stop  = scl_i & r_reg.scl_q & ~r_reg.sda_q & sda_i;

   always_comb begin
      logic [7:0] rd;
      logic [3:0] eff_sel;
      logic [3:0] go_set;
      logic [4:0] goal;
      rd       = 8'h00;
      go_set   = 4'h0;
      goal     = 5'h00;
      r_next   = r_reg;
      r_next.scl_q = scl_i;
      r_next.sda_q = sda_i;
      r_next.stb_q = standby_select_pin_i;
      eff_sel  = r_reg.sel | {4{standby_select_pin_i}};

      // standby edges retarget every rail
      if (standby_select_pin_i != r_reg.stb_q) begin
         go_set = 4'hf;
      end

      // reference slew engines
      for (int i = 0; i < 4; i++) begin
         goal = target_code(r_reg.tgt[i], eff_sel[i]);
         if (!r_reg.go[i]) begin
            r_next.step_cnt[i] = 12'h000;
         end else if (r_reg.cur[i] == goal) begin
            r_next.go[i]       = 1'b0;
            r_next.step_cnt[i] = 12'h000;
         end else if (r_reg.step_cnt[i] == step_cycles(r_reg.ramp[2*i+:2]) - 12'h001) begin
            r_next.step_cnt[i] = 12'h000;
            r_next.cur[i] = (r_reg.cur[i] < goal) ? r_reg.cur[i] + 5'h01 : r_reg.cur[i] - 5'h01;
         end else begin
            r_next.step_cnt[i] = r_reg.step_cnt[i] + 12'h001;
         end
      end

      // serial port slave
      if (bus_start) begin
         r_next.state    = dvs_ref_pkg::S_ADDR;
         r_next.bit_cnt  = 4'h0;
         r_next.sda_oe_n = 1'b1;
      end else if (bus_stop) begin
         r_next.state    = dvs_ref_pkg::S_IDLE;
         r_next.sda_oe_n = 1'b1;
      end else begin
         unique case (r_reg.state)
            dvs_ref_pkg::S_IDLE: begin
               r_next.sda_oe_n = 1'b1;
            end
            dvs_ref_pkg::S_ADDR, dvs_ref_pkg::S_SUB, dvs_ref_pkg::S_WDATA: begin
               if (scl_rise) begin
                  r_next.shift   = {r_reg.shift[6:0], sda_i};
                  r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
               end else if (scl_fall && r_reg.bit_cnt == 4'h8) begin
                  r_next.sda_oe_n = 1'b0;
                  if (r_reg.state == dvs_ref_pkg::S_ADDR) begin
                     if (r_reg.shift[7:1] == dvs_ref_pkg::DEV_ADDR) begin
                        r_next.rw    = r_reg.shift[0];
                        r_next.state = dvs_ref_pkg::S_ADDR_ACK;
                     end else begin
                        r_next.sda_oe_n = 1'b1;
                        r_next.state    = dvs_ref_pkg::S_IDLE;
                     end
                  end else if (r_reg.state == dvs_ref_pkg::S_SUB) begin
                     r_next.ptr   = r_reg.shift;
                     r_next.state = dvs_ref_pkg::S_SUB_ACK;
                     if (r_reg.shift == dvs_ref_pkg::ALERT_CLEAR_OFS) begin
                        r_next.alert_n = 1'b1;
                     end
                  end else begin
                     r_next.state = dvs_ref_pkg::S_WACK;
                     unique case (r_reg.ptr)
                        dvs_ref_pkg::VCC_CONTROL_OFS: begin
                           r_next.sel = {r_reg.shift[7], r_reg.shift[5],
                                         r_reg.shift[3], r_reg.shift[1]};
                           go_set = go_set | {r_reg.shift[6], r_reg.shift[4],
                                              r_reg.shift[2], r_reg.shift[0]};
                        end
                        dvs_ref_pkg::RAMP_RATE_OFS:    r_next.ramp = r_reg.shift;
                        dvs_ref_pkg::BUCK1_FIRST_OFS:
                           r_next.tgt[0].first = r_reg.shift & dvs_ref_pkg::BUCK1_FIRST_WMASK;
                        dvs_ref_pkg::BUCK1_SECOND_OFS:
                           r_next.tgt[0].second = r_reg.shift & dvs_ref_pkg::SECOND_WMASK;
                        dvs_ref_pkg::BUCK2_FIRST_OFS:
                           r_next.tgt[1].first = r_reg.shift & dvs_ref_pkg::BUCKX_FIRST_WMASK;
                        dvs_ref_pkg::BUCK2_SECOND_OFS:
                           r_next.tgt[1].second = r_reg.shift & dvs_ref_pkg::SECOND_WMASK;
                        dvs_ref_pkg::BUCK3_FIRST_OFS:
                           r_next.tgt[2].first = r_reg.shift & dvs_ref_pkg::BUCKX_FIRST_WMASK;
                        dvs_ref_pkg::BUCK3_SECOND_OFS:
                           r_next.tgt[2].second = r_reg.shift & dvs_ref_pkg::SECOND_WMASK;
                        dvs_ref_pkg::LDO2_FIRST_OFS:
                           r_next.tgt[3].first = r_reg.shift & dvs_ref_pkg::LDO2_FIRST_WMASK;
                        dvs_ref_pkg::LDO2_SECOND_OFS:
                           r_next.tgt[3].second = r_reg.shift & dvs_ref_pkg::SECOND_WMASK;
                        default: ; // alert clear, status and holes keep nothing
                     endcase
                  end
               end
            end
            dvs_ref_pkg::S_ADDR_ACK: begin
               if (scl_fall) begin
                  r_next.bit_cnt = 4'h0;
                  if (r_reg.rw) begin
                     rd = read_reg(r_reg, fault_status_i, rail_good_i);
                     r_next.sda_oe_n = rd[7];
                     r_next.shift    = {rd[6:0], 1'b0};
                     r_next.bit_cnt  = 4'h1;
                     r_next.state    = dvs_ref_pkg::S_RDATA;
                  end else begin
                     r_next.sda_oe_n = 1'b1;
                     r_next.state    = dvs_ref_pkg::S_SUB;
                  end
               end
            end
            dvs_ref_pkg::S_SUB_ACK, dvs_ref_pkg::S_WACK: begin
               if (scl_fall) begin
                  r_next.sda_oe_n = 1'b1;
                  r_next.bit_cnt  = 4'h0;
                  r_next.state    = dvs_ref_pkg::S_WDATA;
               end
            end
            dvs_ref_pkg::S_RDATA: begin
               if (scl_fall) begin
                  if (r_reg.bit_cnt == 4'h8) begin
                     r_next.sda_oe_n = 1'b1;
                     r_next.state    = dvs_ref_pkg::S_RACK;
                  end else begin
                     r_next.sda_oe_n = r_reg.shift[7];
                     r_next.shift    = {r_reg.shift[6:0], 1'b0};
                     r_next.bit_cnt  = r_reg.bit_cnt + 4'h1;
                  end
               end
            end
            dvs_ref_pkg::S_RACK: begin
               if (scl_rise) begin
                  r_next.nack = sda_i;
               end else if (scl_fall) begin
                  if (r_reg.nack) begin
                     r_next.state = dvs_ref_pkg::S_IDLE;
                  end else begin
                     rd = read_reg(r_reg, fault_status_i, rail_good_i);
                     r_next.sda_oe_n = rd[7];
                     r_next.shift    = {rd[6:0], 1'b0};
                     r_next.bit_cnt  = 4'h1;
                     r_next.state    = dvs_ref_pkg::S_RDATA;
                  end
               end
            end
            default: begin
               r_next.state    = dvs_ref_pkg::S_IDLE;
               r_next.sda_oe_n = 1'b1;
            end
         endcase
      end

      // a write of go wins over the engine's own clear
      r_next.go = r_next.go | go_set;

      // a new fault wins over a clear in the same cycle
      if (fault_event_i) begin
         r_next.alert_n = 1'b0;
      end

      for (int i = 0; i < 4; i++) begin
         pg_force[i] = r_next.go[i] & ~r_reg.tgt[i].first[dvs_ref_pkg::PG_MASK_BIT];
      end
      r_next.pg = power_ok_i & ~|pg_force;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_reg <= RESET_STATE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sda_o            = 1'b0;
   assign sda_oe_n_o       = r_reg.sda_oe_n;
   assign alert_n_o        = r_reg.alert_n;
   assign power_good_out_o = r_reg.pg;
   assign ref_code_o       = r_reg.cur;
   assign slewing_o        = r_reg.go;
   assign edge_rate_o      = r_reg.tgt[0].first[dvs_ref_pkg::EDGE_MSB:dvs_ref_pkg::EDGE_LSB];
   assign freq_sel_o       = {r_reg.tgt[2].second[dvs_ref_pkg::FREQ_BIT],
                              r_reg.tgt[1].second[dvs_ref_pkg::FREQ_BIT],
                              r_reg.tgt[0].second[dvs_ref_pkg::FREQ_BIT]};

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_clear_at_ack;
      (r_reg.state == dvs_ref_pkg::S_SUB && scl_fall && r_reg.bit_cnt == 4'h8 && !bus_start
       && !bus_stop && r_reg.shift == dvs_ref_pkg::ALERT_CLEAR_OFS && !fault_event_i)
      |=> alert_n_o && !sda_oe_n_o;
   endproperty
   a_clear_at_ack: assert property (p_clear_at_ack) else $error("alert not cleared at ack");

   property p_fault_wins;
      fault_event_i |=> !alert_n_o;
   endproperty
   a_fault_wins: assert property (p_fault_wins) else $error("fault event lost");

   property p_clear_reg_discard;
      (r_reg.state == dvs_ref_pkg::S_WDATA && r_reg.ptr == dvs_ref_pkg::ALERT_CLEAR_OFS)
      |=> $stable(r_reg.tgt) && $stable(r_reg.sel) && $stable(r_reg.ramp);
   endproperty
   a_clear_reg_discard: assert property (p_clear_reg_discard) else $error("clear data stored");

   property p_go_self_clear;
      (r_reg.go[0] && r_reg.cur[0] == target_code(r_reg.tgt[0], r_reg.sel[0] | r_reg.stb_q)
       && standby_select_pin_i == r_reg.stb_q && r_reg.state != dvs_ref_pkg::S_WDATA)
      |=> !slewing_o[0];
   endproperty
   a_go_self_clear: assert property (p_go_self_clear) else $error("go bit not cleared");

   property p_pg_forced_low;
      (|(r_reg.go & ~{r_reg.tgt[3].first[5], r_reg.tgt[2].first[5], r_reg.tgt[1].first[5],
                      r_reg.tgt[0].first[5]})) ##1 (r_reg.go == $past(r_reg.go))
      |-> !power_good_out_o;
   endproperty
   a_pg_forced_low: assert property (p_pg_forced_low) else $error("power good high in slew");

   property p_standby_launch;
      (standby_select_pin_i != r_reg.stb_q) |=> slewing_o == 4'hf;
   endproperty
   a_standby_launch: assert property (p_standby_launch) else $error("standby did not launch");

   property p_single_step;
      $changed(ref_code_o[0]) |-> (ref_code_o[0] == $past(ref_code_o[0]) + 5'h01)
                                  || (ref_code_o[0] == $past(ref_code_o[0]) - 5'h01);
   endproperty
   a_single_step: assert property (p_single_step) else $error("reference jumped");

   property p_step_spacing;
      ($changed(ref_code_o[3]) && r_reg.ramp[7:6] == 2'h3 && slewing_o[3]) ##1
         (slewing_o[3] && $stable(r_reg.ramp))[*8] |-> $stable(ref_code_o[3]);
   endproperty
   a_step_spacing: assert property (p_step_spacing) else $error("step too fast");

endmodule

// File: testbench/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   // each scl phase lasts 6 core clocks, data moves mid low phase
   localparam int HALF = 6;
   logic [6:0] dev = dvs_ref_pkg::DEV_ADDR;

   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic gap(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic clock_bit(input logic b, output logic s);
      gap(HALF / 2);
      sda_o = b;
      gap(HALF / 2);
      scl_o = 1'b1;
      gap(HALF);
      s = sda_i;
      scl_o = 1'b0;
   endtask

   // one byte out and in at once; a one on sda_o releases the pulled-up line
   task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                       output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(tx[i], rx[i]);
      end
      clock_bit(last, a);
      ack = ~a;
   endtask

   task automatic start_cond();
      gap(HALF / 2);
      sda_o = 1'b1;
      gap(HALF / 2);
      scl_o = 1'b1;
      gap(HALF);
      sda_o = 1'b0;
      gap(HALF);
      scl_o = 1'b0;
   endtask

   task automatic stop_cond();
      gap(HALF / 2);
      sda_o = 1'b0;
      gap(HALF / 2);
      scl_o = 1'b1;
      gap(HALF);
      sda_o = 1'b1;
      gap(HALF);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic [7:0] rx;
      logic       k0, k1, k2;
      start_cond();
      xfer({dev, 1'b0}, 1'b1, rx, k0);
      xfer(a, 1'b1, rx, k1);
      xfer(d, 1'b1, rx, k2);
      stop_cond();
      ok = k0 & k1 & k2;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      logic [7:0] rx;
      logic       k0, k1, k2, kn;
      start_cond();
      xfer({dev, 1'b0}, 1'b1, rx, k0);
      xfer(a, 1'b1, rx, k1);
      start_cond();
      xfer({dev, 1'b1}, 1'b1, rx, k2);
      xfer(8'hff, 1'b1, d, kn);
      stop_cond();
      ok = k0 & k1 & k2;
   endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
   logic                      core_clk = 1'b0;
   logic                      rst_n    = 1'b0;
   logic                      standby  = 1'b0;
   logic                      fault_ev = 1'b0;
   logic [4:0]                fault_st = 5'h15;
   logic [7:0]                rail_gd  = 8'h5a;
   logic                      pwr_ok   = 1'b1;
   logic                      scl, host_sda, sda_dut, sda_oe_n, sda_w, alert_n, pg, ok;
   dvs_ref_pkg::rail_codes_t  ref_code;
   logic [3:0]                slewing;
   logic [1:0]                edge_rate;
   logic [2:0]                freq_sel;
   int                        err_total = 0;
   int                        n_checks  = 0;
   localparam logic [7:0] TGT [6] = '{8'h26, 8'h27, 8'h29, 8'h2a, 8'h32, 8'h33};

   always #2 core_clk = ~core_clk;
   assign sda_w = host_sda & (sda_oe_n | sda_dut);

   serial_host_model host_u (.clk_i(core_clk), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));

   dvs_reference_control dut_u (
      .core_clk_i(core_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_dut),
      .sda_oe_n_o(sda_oe_n), .standby_select_pin_i(standby), .fault_event_i(fault_ev),
      .fault_status_i(fault_st), .rail_good_i(rail_gd), .power_ok_i(pwr_ok),
      .alert_n_o(alert_n), .power_good_out_o(pg), .ref_code_o(ref_code),
      .slewing_o(slewing), .edge_rate_o(edge_rate), .freq_sel_o(freq_sel));

   task automatic wrap_up();
      if (err_total == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_u.wr(a, d, ok);
      `CHK("write ack", 1'b1, ok)
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host_u.rd(a, d, ok);
      `CHK("read data", e, d)
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      while (slewing !== 4'h0 && k < 8000) begin
         @(negedge core_clk);
         k++;
      end
      `CHK("slew finished", 1'b1, k < 8000)
   endtask

   initial begin
      repeat (60000) @(posedge core_clk);
      err_total++;
      wrap_up();
   end

   initial begin
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      `CHK("reset codes", {4{5'h19}}, ref_code)
      foreach (TGT[i]) rd_chk(TGT[i], 8'h19);
      rd_chk(dvs_ref_pkg::RAMP_RATE_OFS, 8'hff);
      wr(8'h29, 8'hff);
      rd_chk(8'h29, 8'h3f);
      wr(8'h32, 8'hff);
      rd_chk(8'h32, 8'hbf);
      wr(8'h23, 8'hd9);
      wr(8'h24, 8'h3a);
      wr(8'h27, 8'h3b);
      wr(8'h2a, 8'h3a);
      wr(8'h33, 8'h17);
      `CHK("edge rate", 2'b11, edge_rate)
      `CHK("frequency select", 3'b111, freq_sel)
      // select alone must leave the reference where it is
      wr(dvs_ref_pkg::VCC_CONTROL_OFS, 8'h08);
      repeat (50) @(negedge core_clk);
      `CHK("no slew without go", {5'h19, 4'h0}, {ref_code[1], slewing})
      wr(dvs_ref_pkg::VCC_CONTROL_OFS, 8'h0c);
      `CHK("slewing rail1", 2'b10, {slewing[1], pg})
      wait_idle();
      `CHK("rail1 code", 5'h1b, ref_code[1])
      `CHK("power good after", 1'b1, pg)
      rd_chk(dvs_ref_pkg::VCC_CONTROL_OFS, 8'h08);
      wr(dvs_ref_pkg::VCC_CONTROL_OFS, 8'h18);
      `CHK("masked slew", 2'b11, {slewing[2], pg})
      wait_idle();
      `CHK("rail2 code", 5'h1f, ref_code[2])
      standby = 1'b1;
      repeat (3) @(negedge core_clk);
      wait_idle();
      `CHK("standby codes", {5'h17, 5'h1a, 5'h1b, 5'h1a}, ref_code)
      // rails 3..0 at rates 3,2,1,0: only the faster rails may have stepped so far
      wr(dvs_ref_pkg::RAMP_RATE_OFS, 8'he4);
      rd_chk(dvs_ref_pkg::RAMP_RATE_OFS, 8'he4);
      standby = 1'b0;
      repeat (3500) @(negedge core_clk);
      `CHK("rate spacing", {5'h1e, 5'h1d, 5'h1b, 5'h1a, 1'b0}, {ref_code, pg})
      wait_idle();
      `CHK("first codes", {5'h1f, 5'h1f, 5'h1b, 5'h19}, ref_code)
      fault_ev = 1'b1;
      @(negedge core_clk);
      fault_ev = 1'b0;
      repeat (2) @(negedge core_clk);
      `CHK("alert raised", 1'b0, alert_n)
      rd_chk(dvs_ref_pkg::FAULT_STATUS_OFS, 8'ha8);
      wr(dvs_ref_pkg::PG_STATUS_OFS, 8'h00);
      rd_chk(dvs_ref_pkg::PG_STATUS_OFS, 8'h5a);
      `CHK("alert held", 1'b0, alert_n)
      wr(dvs_ref_pkg::ALERT_CLEAR_OFS, 8'h55);
      `CHK("alert cleared", 1'b1, alert_n)
      rd_chk(dvs_ref_pkg::ALERT_CLEAR_OFS, 8'h00);
      wr(8'h30, 8'ha5);
      rd_chk(8'h30, 8'h00);
      host_u.dev = 7'h35;
      host_u.wr(8'h33, 8'h0f, ok);
      `CHK("foreign address ack", 1'b0, ok)
      host_u.dev = dvs_ref_pkg::DEV_ADDR;
      rd_chk(8'h33, 8'h17);
      wrap_up();
   end
endmodule
